// ===== hw/cpurf_map.vh
`ifndef CPURF_MAP_VH
`define CPURF_MAP_VH

// Data-space map of the register file and pointer registers
`define CPURF_RF_LAST 16'h001F
`define CPURF_IO_OFS 16'h0020
`define CPURF_EXT_IO_BASE 16'h0060
`define CPURF_EPB_ADDR 16'h005B
`define CPURF_SP_LO_ADDR 16'h005D
`define CPURF_SP_HI_ADDR 16'h005E
`define CPURF_STAT_ADDR 16'h005F

// Reset values and writable masks
`define CPURF_SP_RST 16'h10FF
`define CPURF_SP_MASK 16'h1FFF
`define CPURF_EPB_RST 8'h00
`define CPURF_STAT_RST 8'h00
`define CPURF_RF_RST 8'h00

// Low register of each indirect pointer pair
`define CPURF_PTR1_LO 5'h1A
`define CPURF_PTR2_LO 5'h1C
`define CPURF_PTR3_LO 5'h1E

// Status byte bit positions
`define CPURF_FLG_C 0
`define CPURF_FLG_Z 1
`define CPURF_FLG_N 2
`define CPURF_FLG_V 3
`define CPURF_FLG_S 4

// Stack operations
`define CPURF_STK_NONE 3'h0
`define CPURF_STK_PUSH1 3'h1
`define CPURF_STK_POP1 3'h2
`define CPURF_STK_PUSH2 3'h3
`define CPURF_STK_POP2 3'h4

// Indirect pointer modes
`define CPURF_PM_DISP 2'h0
`define CPURF_PM_POSTINC 2'h1
`define CPURF_PM_PREDEC 2'h2

`endif

// ===== hw/cpurf_flags.v
`timescale 1ns/100ps
`include "cpurf_map.vh"

module cpurf_flags (
  input wire [7:0] stat_cur, // Current status byte
  input wire alu_we, // ALU flag update strobe
  input wire [15:0] alu_res, // ALU result
  input wire alu_wide, // Result is 16 bits wide
  input wire alu_c, // ALU carry out
  input wire alu_v, // ALU overflow
  input wire bus_we, // Status byte written by software
  input wire [7:0] bus_data, // Software write data
  output reg [7:0] stat_nxt // Next status byte
);

  reg res_zero;
  reg res_neg;

  // ALU update beats a software write in the same cycle; sign always follows N and V
  always @* begin
    res_zero = alu_wide ? (alu_res == 16'h0000) : (alu_res[7:0] == 8'h00);
    res_neg = alu_wide ? alu_res[15] : alu_res[7];
    stat_nxt = stat_cur;
    if (bus_we) begin
      stat_nxt = bus_data;
    end
    if (alu_we) begin
      stat_nxt[`CPURF_FLG_C] = alu_c;
      stat_nxt[`CPURF_FLG_Z] = res_zero; // [RULE2]
      stat_nxt[`CPURF_FLG_N] = res_neg; // [RULE2]
      stat_nxt[`CPURF_FLG_V] = alu_v;
    end
    stat_nxt[`CPURF_FLG_S] = stat_nxt[`CPURF_FLG_N] ^ stat_nxt[`CPURF_FLG_V]; // [RULE1]
  end

endmodule // cpurf_flags

// ===== hw/cpurf_ptr_calc.v
`timescale 1ns/100ps
`include "cpurf_map.vh"

module cpurf_ptr_calc (
  input wire [15:0] ptr_cur, // Current pointer pair value
  input wire [1:0] mode, // Addressing mode
  input wire [5:0] disp, // Fixed displacement
  output reg [15:0] eff_addr, // Effective data address
  output reg [15:0] ptr_nxt, // Updated pointer value
  output reg ptr_chg // Pointer pair must be written back
);

  // Post-increment uses the old value, pre-decrement the new one
  always @* begin
    eff_addr = ptr_cur;
    ptr_nxt = ptr_cur;
    ptr_chg = 1'b0;
    case (mode)
      `CPURF_PM_DISP: begin
        eff_addr = ptr_cur + {10'h000, disp}; // [RULE6]
      end
      `CPURF_PM_POSTINC: begin
        ptr_nxt = ptr_cur + 16'h0001; // [RULE6]
        ptr_chg = 1'b1;
      end
      `CPURF_PM_PREDEC: begin
        ptr_nxt = ptr_cur - 16'h0001; // [RULE6]
        eff_addr = ptr_cur - 16'h0001;
        ptr_chg = 1'b1;
      end
      default: begin
        eff_addr = ptr_cur;
      end
    endcase
  end

endmodule // cpurf_ptr_calc

// ===== hw/cpurf_top.v
`timescale 1ns/100ps
`include "cpurf_map.vh"

// Summary of operation
// RULE1: Sign flag always equals N xor V
// RULE2: Status bits C,Z,N,V,S at 0..4
// RULE3: Four read/write port width schemes supported
// RULE4: Registers mapped at data addresses 0x00-0x1F
// RULE5: Three pointer pairs, low byte first
// RULE6: Pointers support displacement, increment, decrement
// RULE7: Stack grows downward from stack pointer
// RULE8: Byte push minus one, pop plus one
// RULE9: Calls and interrupt entry subtract two
// RULE10: Returns add two to stack pointer
// RULE11: Stack pointer resets to 0x10FF
// RULE12: Stack pointer at 0x5D, top bits zero
// RULE13: I/O addresses map to data plus 0x20
// RULE14: Extended I/O unreachable by I/O instructions
// RULE15: Extended program address prefixes pointer byte
// RULE16: Plain program load ignores pointer byte
// RULE17: Extended pointer byte at 0x5B, resets zero
// RULE18: Unused pointer byte bits read zero
// RULE19: Software writes zero to unused bits
// RULE20: Software sets stack before calls, interrupts
// RULE21: 16-bit write low first via temp
// RULE22: 16-bit read low first latches high
// RULE23: Push stores then decrements; pop increments first
module cpurf_top #(
  parameter EPB_BITS = 8 // Implemented bits of the extended pointer byte
) (
  input wire clk, // CPU clock
  input wire rst_b, // Asynchronous reset, active low
  input wire [4:0] rd_a_idx, // First 8-bit operand index
  input wire [4:0] rd_b_idx, // Second 8-bit operand index
  input wire [3:0] rd_w_idx, // 16-bit operand pair index
  output reg [7:0] rd_a_q, // First 8-bit operand
  output reg [7:0] rd_b_q, // Second 8-bit operand
  output reg [15:0] rd_w_q, // 16-bit operand
  input wire wr_en, // Result write strobe
  input wire wr_wide, // Result is 16 bits into a pair
  input wire [4:0] wr_idx, // Result destination index
  input wire [15:0] wr_data, // Result data
  input wire alu_flag_we, // ALU flag update strobe
  input wire [15:0] alu_res, // ALU result for Z and N
  input wire alu_wide, // ALU result is 16 bits
  input wire alu_c, // ALU carry
  input wire alu_v, // ALU overflow
  output reg [7:0] status_byte_q, // Status byte
  input wire acc_en, // Load or store strobe
  input wire acc_we, // Store when high, load when low
  input wire acc_io, // Dedicated I/O instruction address
  input wire [15:0] acc_addr, // Data address, or I/O address in low 6 bits
  input wire [7:0] acc_wdata, // Store data
  output reg [7:0] acc_rdata_q, // Load data
  output reg acc_hit_q, // Access decoded by this block
  input wire ptr_en, // Indirect access through a pointer pair
  input wire [1:0] ptr_sel, // Pointer pair 0..2
  input wire [1:0] ptr_mode, // Displacement, post-increment, pre-decrement
  input wire [5:0] ptr_disp, // Displacement
  output reg [15:0] ptr_addr_q, // Effective indirect address
  input wire [2:0] stk_op, // Stack operation
  output reg [15:0] stk_addr_q, // Stack access address
  output reg [15:0] stack_pointer_q, // Stack pointer
  input wire pm_en, // Program memory access through the third pair
  input wire pm_ext, // Extended load or program store
  output reg [23:0] pm_addr_q, // Program memory byte address
  output reg [7:0] extended_pointer_byte_q // Extended pointer byte
);

  localparam [7:0] EPB_MASK = 8'hFF >> (8 - EPB_BITS);

  // Register file storage and read view
  wire [7:0] rf_w [0:31];

  // Address decode
  reg [15:0] eff_addr;
  reg hit_rf;
  reg hit_epb;
  reg hit_sp_lo;
  reg hit_sp_hi;
  reg hit_stat;
  wire bus_wr;
  wire bus_rd;

  // Pointer path
  reg ptr_sel_ok;
  reg [4:0] ptr_lo_idx;
  wire [15:0] ptr_cur;
  wire [15:0] ptr_eff;
  wire [15:0] ptr_nxt;
  wire ptr_chg;
  wire ptr_upd;
  wire [15:0] third_pointer;

  // Stack and temporary byte
  reg [15:0] sp_d;
  reg [15:0] stk_addr_d;
  reg [7:0] tmp_q;
  reg [7:0] tmp_d;
  wire [7:0] stat_nxt;
  reg [7:0] rdata_d;
  reg hit_d;

  // I/O instructions see only 64 addresses, so they can never reach 0x60 and up
  always @* begin
    if (acc_io) begin
      eff_addr = {10'h000, acc_addr[5:0]} + `CPURF_IO_OFS; // [RULE13] [RULE14]
    end else begin
      eff_addr = acc_addr;
    end
    hit_rf = (eff_addr <= `CPURF_RF_LAST); // [RULE4]
    hit_epb = (eff_addr == `CPURF_EPB_ADDR); // [RULE17]
    hit_sp_lo = (eff_addr == `CPURF_SP_LO_ADDR); // [RULE12]
    hit_sp_hi = (eff_addr == `CPURF_SP_HI_ADDR); // [RULE12]
    hit_stat = (eff_addr == `CPURF_STAT_ADDR);
  end

  assign bus_wr = acc_en & acc_we;
  assign bus_rd = acc_en & ~acc_we;

  // Pointer pair selection; code 3 selects nothing and leaves every pair alone
  always @* begin
    ptr_sel_ok = 1'b1;
    case (ptr_sel)
      2'h0: begin
        ptr_lo_idx = `CPURF_PTR1_LO; // [RULE5]
      end
      2'h1: begin
        ptr_lo_idx = `CPURF_PTR2_LO; // [RULE5]
      end
      2'h2: begin
        ptr_lo_idx = `CPURF_PTR3_LO; // [RULE5]
      end
      default: begin
        ptr_lo_idx = `CPURF_PTR3_LO;
        ptr_sel_ok = 1'b0;
      end
    endcase
  end
  assign ptr_cur = {rf_w[ptr_lo_idx | 5'h01], rf_w[ptr_lo_idx]}; // [RULE5]
  assign ptr_upd = ptr_en & ptr_sel_ok & ptr_chg;
  assign third_pointer = {rf_w[`CPURF_PTR3_LO | 5'h01], rf_w[`CPURF_PTR3_LO]};

  cpurf_ptr_calc u_ptr (
    .ptr_cur(ptr_cur),
    .mode(ptr_mode),
    .disp(ptr_disp),
    .eff_addr(ptr_eff),
    .ptr_nxt(ptr_nxt),
    .ptr_chg(ptr_chg)
  );

  cpurf_flags u_flags (
    .stat_cur(status_byte_q),
    .alu_we(alu_flag_we),
    .alu_res(alu_res),
    .alu_wide(alu_wide),
    .alu_c(alu_c),
    .alu_v(alu_v),
    .bus_we(bus_wr & hit_stat),
    .bus_data(acc_wdata),
    .stat_nxt(stat_nxt)
  );

  // One byte register per entry; result port beats pointer update beats store
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_rf
      localparam [4:0] IDX = gi;
      reg [7:0] byte_q;
      reg [7:0] byte_d;
      always @* begin
        byte_d = byte_q;
        if (wr_en && wr_wide && (wr_idx[4:1] == IDX[4:1])) begin
          byte_d = IDX[0] ? wr_data[15:8] : wr_data[7:0]; // [RULE3]
        end else if (wr_en && !wr_wide && (wr_idx == IDX)) begin
          byte_d = wr_data[7:0]; // [RULE3]
        end else if (ptr_upd && (ptr_lo_idx[4:1] == IDX[4:1])) begin
          byte_d = IDX[0] ? ptr_nxt[15:8] : ptr_nxt[7:0]; // [RULE6]
        end else if (bus_wr && hit_rf && (eff_addr[4:0] == IDX)) begin
          byte_d = acc_wdata; // [RULE4]
        end
      end
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          byte_q <= `CPURF_RF_RST;
        end else begin
          byte_q <= byte_d;
        end
      end
      assign rf_w[gi] = byte_q;
    end
  endgenerate

  // Stack pointer: byte push/pop move by one, call/return by two
  always @* begin
    sp_d = stack_pointer_q;
    stk_addr_d = stk_addr_q;
    case (stk_op)
      `CPURF_STK_PUSH1: begin
        stk_addr_d = stack_pointer_q; // [RULE23]
        sp_d = stack_pointer_q - 16'h0001; // [RULE7] [RULE8]
      end
      `CPURF_STK_POP1: begin
        sp_d = stack_pointer_q + 16'h0001; // [RULE8]
        stk_addr_d = sp_d; // [RULE23]
      end
      `CPURF_STK_PUSH2: begin
        stk_addr_d = stack_pointer_q; // [RULE23]
        sp_d = stack_pointer_q - 16'h0002; // [RULE9]
      end
      `CPURF_STK_POP2: begin
        stk_addr_d = stack_pointer_q + 16'h0001; // [RULE23]
        sp_d = stack_pointer_q + 16'h0002; // [RULE10]
      end
      default: begin
        sp_d = stack_pointer_q;
      end
    endcase
    // Software write of the high byte lands both bytes at once; it wins over a stack op
    if (bus_wr && hit_sp_hi) begin
      sp_d = {acc_wdata, tmp_q}; // [RULE21]
    end
    sp_d = sp_d & `CPURF_SP_MASK; // [RULE12]
    stk_addr_d = stk_addr_d & `CPURF_SP_MASK; // Pop address wraps like the pointer
  end

  // Temporary byte shared by the 16-bit stack pointer accesses
  always @* begin
    tmp_d = tmp_q;
    if (bus_wr && hit_sp_lo) begin
      tmp_d = acc_wdata; // [RULE21]
    end else if (bus_rd && hit_sp_lo) begin
      tmp_d = stack_pointer_q[15:8]; // [RULE22]
    end
  end

  // Load data mux; unmapped addresses return zero with the hit flag low
  always @* begin
    rdata_d = 8'h00;
    hit_d = acc_en & (hit_rf | hit_epb | hit_sp_lo | hit_sp_hi | hit_stat);
    if (bus_rd) begin
      if (hit_rf) begin
        rdata_d = rf_w[eff_addr[4:0]]; // [RULE4]
      end else if (hit_epb) begin
        rdata_d = extended_pointer_byte_q & EPB_MASK; // [RULE18]
      end else if (hit_sp_lo) begin
        rdata_d = stack_pointer_q[7:0];
      end else if (hit_sp_hi) begin
        rdata_d = tmp_q; // [RULE22]
      end else if (hit_stat) begin
        rdata_d = status_byte_q;
      end
    end
  end

  // Stack pointer and the address of the current stack access
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stack_pointer_q <= `CPURF_SP_RST; // [RULE11]
      stk_addr_q <= `CPURF_SP_RST;
    end else begin
      stack_pointer_q <= sp_d;
      stk_addr_q <= stk_addr_d;
    end
  end

  // Temporary byte for the two-step 16-bit accesses
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tmp_q <= 8'h00;
    end else begin
      tmp_q <= tmp_d;
    end
  end

  // Extended pointer byte; unimplemented bits can never store a one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      extended_pointer_byte_q <= `CPURF_EPB_RST; // [RULE17]
    end else if (bus_wr && hit_epb) begin
      extended_pointer_byte_q <= acc_wdata & EPB_MASK; // [RULE17] [RULE18]
    end
  end

  // Status byte; the sign bit is recomputed by the flag logic every cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_byte_q <= `CPURF_STAT_RST;
    end else begin
      status_byte_q <= stat_nxt; // [RULE1]
    end
  end

  // Load answer stands for exactly one cycle after the access
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_rdata_q <= 8'h00;
      acc_hit_q <= 1'b0;
    end else begin
      acc_rdata_q <= rdata_d;
      acc_hit_q <= hit_d;
    end
  end

  // Byte operand ports, registered so every output leaves a flip-flop
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_a_q <= 8'h00;
      rd_b_q <= 8'h00;
    end else begin
      rd_a_q <= rf_w[rd_a_idx]; // [RULE3]
      rd_b_q <= rf_w[rd_b_idx]; // [RULE3]
    end
  end

  // Word operand port reads an even/odd pair in one go, so it is one cycle late too
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_w_q <= 16'h0000;
    end else begin
      rd_w_q <= {rf_w[{rd_w_idx, 1'b1}], rf_w[{rd_w_idx, 1'b0}]}; // [RULE3]
    end
  end

  // Indirect address holds until the next pointer request that selects pair 0..2
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_addr_q <= 16'h0000;
    end else if (ptr_en && ptr_sel_ok) begin
      ptr_addr_q <= ptr_eff; // [RULE6]
    end
  end

  // Program address holds; only the extended forms see the pointer byte
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pm_addr_q <= 24'h00_0000;
    end else if (pm_en) begin
      if (pm_ext) begin
        pm_addr_q <= {extended_pointer_byte_q & EPB_MASK, third_pointer}; // [RULE15]
      end else begin
        pm_addr_q <= {8'h00, third_pointer}; // [RULE16]
      end
    end
  end

endmodule // cpurf_top

// ===== bench/cpurf_alu_model.sv
`timescale 1ns/100ps
// Adder slice of the execution datapath that feeds the flag inputs
module cpurf_alu_model (
  input wire [7:0] a, // First operand
  input wire [7:0] b, // Second operand
  output wire [15:0] res, // Byte result, upper byte zero
  output wire c, // Carry out
  output wire v // Two's complement overflow
);
  wire [8:0] sum;
  // Overflow only when both signs agree and the result sign differs
  assign sum = {1'b0, a} + {1'b0, b};
  assign res = {8'h00, sum[7:0]};
  assign c = sum[8];
  assign v = (a[7] == b[7]) && (sum[7] != a[7]);
endmodule // cpurf_alu_model

// ===== bench/cpurf_top_sva.sv
`timescale 1ns/100ps
`include "cpurf_map.vh"
module cpurf_top_sva (
  input wire clk, // CPU clock
  input wire rst_b, // Reset, active low
  input wire acc_en, // Access strobe
  input wire acc_we, // Store
  input wire acc_io, // I/O address form
  input wire [15:0] acc_addr, // Access address
  input wire [7:0] acc_rdata_q, // Load data
  input wire acc_hit_q, // Decoded here
  input wire [2:0] stk_op, // Stack operation
  input wire [15:0] stack_pointer_q, // Stack pointer
  input wire [7:0] status_byte_q, // Status byte
  input wire pm_en, // Program access
  input wire pm_ext, // Extended form
  input wire [23:0] pm_addr_q, // Program address
  input wire [7:0] extended_pointer_byte_q // Extended byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Byte push, call and return steps are checked only without a competing access, as a store may override them
  chk_sign_xor: assert property (status_byte_q[4] == (status_byte_q[3] ^ status_byte_q[2]))
    else $error("sign flag mismatch");
  chk_sp_reset: assert property ($rose(rst_b) |-> stack_pointer_q == `CPURF_SP_RST)
    else $error("stack pointer reset value wrong");
  chk_sp_push1: assert property (stk_op == 3'h1 && !acc_en |=> stack_pointer_q == (($past(stack_pointer_q) - 16'h0001) & `CPURF_SP_MASK))
    else $error("byte push step wrong");
  chk_sp_push2: assert property (stk_op == 3'h3 && !acc_en |=> stack_pointer_q == (($past(stack_pointer_q) - 16'h0002) & `CPURF_SP_MASK))
    else $error("call push step wrong");
  chk_sp_pop2: assert property (stk_op == 3'h4 && !acc_en |=> stack_pointer_q == (($past(stack_pointer_q) + 16'h0002) & `CPURF_SP_MASK))
    else $error("return pop step wrong");
  chk_sp_top_zero: assert property (stack_pointer_q[15:13] == 3'h0)
    else $error("stack pointer top bits set");
  chk_pm_plain: assert property (pm_en && !pm_ext |=> pm_addr_q[23:16] == 8'h00)
    else $error("plain load used extended byte");
  chk_pm_ext: assert property (pm_en && pm_ext && !acc_en |=> pm_addr_q[23:16] == $past(extended_pointer_byte_q))
    else $error("extended address prefix wrong");
  chk_epb_read: assert property (acc_en && !acc_we && !acc_io && acc_addr == 16'h005B
    |=> acc_hit_q && acc_rdata_q == $past(extended_pointer_byte_q))
    else $error("extended byte load wrong");
  chk_ext_io_miss: assert property (acc_en && !acc_io && acc_addr >= 16'h0060 |=> !acc_hit_q)
    else $error("extended area decoded");
  cov_push1: cover property (stk_op == 3'h1);
  cov_pm_ext: cover property (pm_en && pm_ext);
  cov_hit: cover property (acc_hit_q);
endmodule // cpurf_top_sva
bind cpurf_top cpurf_top_sva i_sva (.clk(clk), .rst_b(rst_b), .acc_en(acc_en), .acc_we(acc_we), .acc_io(acc_io),
  .acc_addr(acc_addr), .acc_rdata_q(acc_rdata_q), .acc_hit_q(acc_hit_q), .stk_op(stk_op),
  .stack_pointer_q(stack_pointer_q), .status_byte_q(status_byte_q), .pm_en(pm_en), .pm_ext(pm_ext),
  .pm_addr_q(pm_addr_q), .extended_pointer_byte_q(extended_pointer_byte_q));

// ===== bench/cpurf_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 0, rst_b = 0, wr_en = 0, wr_wide = 0, alu_flag_we = 0, acc_en = 0, acc_we = 0, acc_io = 0;
  logic ptr_en = 0, pm_en = 0, pm_ext = 0, alu_wide = 0;
  logic [4:0] rd_a_idx = 5'h05, rd_b_idx = 5'h1F, wr_idx = 0;
  logic [3:0] rd_w_idx = 4'hD;
  logic [15:0] wr_data = 0, acc_addr = 0, e;
  logic [7:0] acc_wdata = 0, alu_a = 0, alu_b = 0;
  logic [1:0] ptr_sel = 0, ptr_mode = 0;
  logic [5:0] ptr_disp = 0;
  logic [2:0] stk_op = 0;
  wire [7:0] rd_a_q, rd_b_q, status_byte_q, acc_rdata_q, extended_pointer_byte_q;
  wire [15:0] rd_w_q, alu_res, ptr_addr_q, stk_addr_q, stack_pointer_q;
  wire [23:0] pm_addr_q;
  wire acc_hit_q, alu_c, alu_v;
  int n_mismatch = 0, comparisons = 0, cyc = 0, i;
  // Per stack op: pointer step and address offset from the old pointer
  logic [2:0] ops [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  logic [15:0] dsp [4] = '{16'hFFFF, 16'h0001, 16'hFFFE, 16'h0002};
  logic [15:0] aof [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001};
  logic [7:0] fa [4] = '{8'h7F, 8'hFF, 8'h80, 8'h00}, fb [4] = '{8'h01, 8'h01, 8'h80, 8'h80};
  logic [7:0] fs [4] = '{8'h0C, 8'h03, 8'h1B, 8'h00}; // Last is a wide result, low byte alone looks negative
  logic [15:0] pa [3] = '{16'h0103, 16'h0100, 16'h0100}, pp [3] = '{16'h0100, 16'h0101, 16'h0100};

  always #4 clk = ~clk;
  cpurf_alu_model i_alu (.a(alu_a), .b(alu_b), .res(alu_res), .c(alu_c), .v(alu_v));
  cpurf_top i_dut (.clk(clk), .rst_b(rst_b), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx), .rd_w_idx(rd_w_idx),
    .rd_a_q(rd_a_q), .rd_b_q(rd_b_q), .rd_w_q(rd_w_q), .wr_en(wr_en), .wr_wide(wr_wide), .wr_idx(wr_idx),
    .wr_data(wr_data), .alu_flag_we(alu_flag_we), .alu_res(alu_res), .alu_wide(alu_wide), .alu_c(alu_c),
    .alu_v(alu_v), .status_byte_q(status_byte_q), .acc_en(acc_en), .acc_we(acc_we), .acc_io(acc_io),
    .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_rdata_q(acc_rdata_q), .acc_hit_q(acc_hit_q),
    .ptr_en(ptr_en), .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .ptr_disp(ptr_disp), .ptr_addr_q(ptr_addr_q),
    .stk_op(stk_op), .stk_addr_q(stk_addr_q), .stack_pointer_q(stack_pointer_q), .pm_en(pm_en),
    .pm_ext(pm_ext), .pm_addr_q(pm_addr_q), .extended_pointer_byte_q(extended_pointer_byte_q));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Ends a request: one edge takes it, strobes drop, outputs settle
  task fin;
    @(posedge clk);
    {acc_en, wr_en, ptr_en, pm_en, alu_flag_we} <= 5'h00;
    stk_op <= 3'h0;
    #1;
  endtask
  task acc(input logic we, input logic io, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    {acc_en, acc_we, acc_io, acc_addr, acc_wdata} <= {1'b1, we, io, a, d};
    fin;
  endtask
  // Guard against a hang; the whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      tally_and_finish;
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    #1;
    `CHK("sp rst", 16'h10FF, stack_pointer_q)
    `CHK("epb rst", 8'h00, extended_pointer_byte_q)
    acc(0, 0, 16'h005D, 0); `CHK("sp lo rd", 8'hFF, acc_rdata_q)
    acc(0, 0, 16'h005E, 0); `CHK("sp hi rd", 8'h10, acc_rdata_q)
    $display("test reset done");
    // Stack set up before any push or call; top bits written as ones must drop
    acc(1, 0, 16'h005D, 8'h34); acc(1, 0, 16'h005E, 8'hEA);
    `CHK("sp wr", 16'h0A34, stack_pointer_q)
    acc(0, 1, 16'h003D, 0); `CHK("sp lo io", 8'h34, acc_rdata_q)
    acc(0, 1, 16'h003E, 0); `CHK("sp hi io", 8'h0A, acc_rdata_q)
    for (i = 0; i < 4; i++) begin
      e = stack_pointer_q;
      @(posedge clk);
      stk_op <= ops[i];
      fin;
      `CHK("sp step", e + dsp[i], stack_pointer_q)
      `CHK("stk addr", e + aof[i], stk_addr_q)
    end
    $display("test stack done");
    // All eight bits implemented, so any pattern is legal to write
    acc(1, 1, 16'h003B, 8'hA5); acc(0, 0, 16'h005B, 0); `CHK("epb", 8'hA5, acc_rdata_q)
    acc(0, 0, 16'h0060, 0); `CHK("ext hit", 1'b0, acc_hit_q)
    @(posedge clk);
    {wr_en, wr_wide, wr_idx, wr_data} <= {1'b1, 1'b1, 5'd30, 16'h5678};
    fin;
    @(posedge clk);
    {pm_en, pm_ext} <= 2'b11;
    fin; `CHK("pm ext", 24'hA5_5678, pm_addr_q)
    @(posedge clk);
    {pm_en, pm_ext} <= 2'b10;
    fin; `CHK("pm plain", 24'h00_5678, pm_addr_q)
    `CHK("rd b", 8'h56, rd_b_q)
    acc(0, 0, 16'h001E, 0); `CHK("r30 ld", 8'h78, acc_rdata_q)
    acc(1, 0, 16'h0005, 8'hC3); fin; `CHK("rd a", 8'hC3, rd_a_q)
    $display("test map done");
    @(posedge clk);
    {wr_en, wr_wide, wr_idx, wr_data} <= {1'b1, 1'b1, 5'd26, 16'h0100};
    fin;
    for (i = 0; i < 3; i++) begin
      @(posedge clk);
      {ptr_en, ptr_sel, ptr_mode, ptr_disp} <= {1'b1, 2'd0, i[1:0], 6'd3};
      fin; `CHK("ptr addr", pa[i], ptr_addr_q)
      fin; `CHK("ptr pair", pp[i], rd_w_q)
    end
    // Third pair in plain mode, then the unused select code must change nothing
    @(posedge clk);
    {ptr_en, ptr_sel, ptr_mode, ptr_disp} <= {1'b1, 2'd2, 2'd3, 6'd1};
    fin; `CHK("ptr third", 16'h5678, ptr_addr_q)
    @(posedge clk);
    {ptr_en, ptr_sel, ptr_mode, ptr_disp} <= {1'b1, 2'd3, 2'd0, 6'd1};
    fin; `CHK("ptr none", 16'h5678, ptr_addr_q)
    $display("test pointer done");
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {alu_a, alu_b, alu_flag_we, alu_wide} <= {fa[i], fb[i], 1'b1, i == 3};
      fin; `CHK("status", fs[i], status_byte_q)
    end
    // Software store with S inconsistent: the sign bit must follow N xor V
    acc(1, 0, 16'h005F, 8'hE7); acc(0, 1, 16'h003F, 0); `CHK("status wr", 8'hF7, acc_rdata_q)
    $display("test flags done");
    tally_and_finish;
  end
endmodule // tb
